// [rtl/tpm_fifo.sv]
// parameterised valid/ready fifo for received test data words
module tpm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != CW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage carries no reset to stay a plain ram
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule

// [rtl/tpm_pin_mux.sv]
// test access port sharing four pads with general-purpose port d lines
module tpm_pin_mux (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] pad_in,
  output tpm_pkg::tpm_pad_s pad_drive,
  input wire logic [3:0] periph_enable,
  input wire logic [3:0] periph_select,
  input wire tpm_pkg::tpm_gpio_s gpio_ctl,
  output logic [3:0] gpio_in,
  input wire logic [7:0] capture_word,
  output logic [3:0] instr,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic overflow,
  output tpm_pkg::tpm_tap_e tap_state
);
  function automatic logic is_shift(tpm_pkg::tpm_tap_e s);
    return (s == tpm_pkg::TPM_SHIFT_DR) || (s == tpm_pkg::TPM_SHIFT_IR);
  endfunction

  logic [3:0] sync1_ff, sync2_ff;
  logic [3:0] sel_ff, nxt_sel;
  logic tck_prev_ff;
  logic [3:0] view;
  logic tck_rise, tck_fall;
  tpm_pkg::tpm_tap_e tap_ff, nxt_tap;
  logic [3:0] ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
  logic [7:0] dr_sh_ff, nxt_dr_sh;
  logic tdo_ff, nxt_tdo;
  logic ovf_ff, nxt_ovf;
  logic push, fifo_ready;
  tpm_pkg::tpm_pad_s pad_ff, nxt_pad;

  // pads are asynchronous to core_clk, tck included
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= tpm_pkg::PULLUP_LEVEL;
      sync2_ff <= tpm_pkg::PULLUP_LEVEL;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
    end
  end

  assign nxt_sel = periph_enable & periph_select;

  // test logic sees the pulled-up level on pads lent to the port
  genvar g;
  generate
    for (g = 0; g < tpm_pkg::PIN_COUNT; g++) begin : g_pin
      assign view[g] = sel_ff[g] ? 1'b1 : sync2_ff[g];
      // one continuous driver per bit keeps each pad bit single-sourced
      assign nxt_pad.out[g] = sel_ff[g] ? gpio_ctl.out[g]
        : (g == tpm_pkg::LINE_TDO) ? tdo_ff : 1'b0;
      assign nxt_pad.oe[g] = sel_ff[g] ? gpio_ctl.dir[g]
        : (g == tpm_pkg::LINE_TDO) && is_shift(tap_ff);
    end
  endgenerate

  // no edges while tck is lent out, so switching roles cannot clock
  assign tck_rise = view[tpm_pkg::LINE_TCK] && !tck_prev_ff
                    && !sel_ff[tpm_pkg::LINE_TCK];
  assign tck_fall = !view[tpm_pkg::LINE_TCK] && tck_prev_ff
                    && !sel_ff[tpm_pkg::LINE_TCK];
  assign push = tck_rise && (tap_ff == tpm_pkg::TPM_UPD_DR);

  always_comb begin
    nxt_tap = tap_ff;
    nxt_ir_sh = ir_sh_ff;
    nxt_ir = ir_ff;
    nxt_dr_sh = dr_sh_ff;
    nxt_tdo = tdo_ff;
    nxt_ovf = ovf_ff;
    if (tck_rise) begin
      case (tap_ff)
        tpm_pkg::TPM_TLR: nxt_tap = view[tpm_pkg::LINE_TMS] ?
          tpm_pkg::TPM_TLR : tpm_pkg::TPM_IDLE;
        tpm_pkg::TPM_IDLE, tpm_pkg::TPM_UPD_DR, tpm_pkg::TPM_UPD_IR:
          nxt_tap = view[tpm_pkg::LINE_TMS] ?
            tpm_pkg::TPM_SEL_DR : tpm_pkg::TPM_IDLE;
        tpm_pkg::TPM_SEL_DR: nxt_tap = view[tpm_pkg::LINE_TMS] ?
          tpm_pkg::TPM_SEL_IR : tpm_pkg::TPM_CAP_DR;
        tpm_pkg::TPM_CAP_DR, tpm_pkg::TPM_SHIFT_DR, tpm_pkg::TPM_EXIT2_DR:
          nxt_tap = view[tpm_pkg::LINE_TMS] ?
            tpm_pkg::TPM_EXIT1_DR : tpm_pkg::TPM_SHIFT_DR;
        tpm_pkg::TPM_EXIT1_DR: nxt_tap = view[tpm_pkg::LINE_TMS] ?
          tpm_pkg::TPM_UPD_DR : tpm_pkg::TPM_PAUSE_DR;
        tpm_pkg::TPM_PAUSE_DR: nxt_tap = view[tpm_pkg::LINE_TMS] ?
          tpm_pkg::TPM_EXIT2_DR : tpm_pkg::TPM_PAUSE_DR;
        tpm_pkg::TPM_SEL_IR: nxt_tap = view[tpm_pkg::LINE_TMS] ?
          tpm_pkg::TPM_TLR : tpm_pkg::TPM_CAP_IR;
        tpm_pkg::TPM_CAP_IR, tpm_pkg::TPM_SHIFT_IR, tpm_pkg::TPM_EXIT2_IR:
          nxt_tap = view[tpm_pkg::LINE_TMS] ?
            tpm_pkg::TPM_EXIT1_IR : tpm_pkg::TPM_SHIFT_IR;
        tpm_pkg::TPM_EXIT1_IR: nxt_tap = view[tpm_pkg::LINE_TMS] ?
          tpm_pkg::TPM_UPD_IR : tpm_pkg::TPM_PAUSE_IR;
        tpm_pkg::TPM_PAUSE_IR: nxt_tap = view[tpm_pkg::LINE_TMS] ?
          tpm_pkg::TPM_EXIT2_IR : tpm_pkg::TPM_PAUSE_IR;
        default: nxt_tap = tpm_pkg::TPM_TLR;
      endcase
      case (tap_ff)
        tpm_pkg::TPM_TLR: nxt_ir = tpm_pkg::IR_RESET_VAL;
        tpm_pkg::TPM_CAP_IR: nxt_ir_sh = tpm_pkg::IR_CAPTURE_VAL;
        tpm_pkg::TPM_SHIFT_IR:
          nxt_ir_sh = {view[tpm_pkg::LINE_TDI], ir_sh_ff[3:1]};
        tpm_pkg::TPM_UPD_IR: nxt_ir = ir_sh_ff;
        // other instructions capture zeros, so the word is only sent on ask
        tpm_pkg::TPM_CAP_DR: nxt_dr_sh =
          (ir_ff == tpm_pkg::IR_DATA_SEL) ? capture_word : 8'h00;
        tpm_pkg::TPM_SHIFT_DR:
          nxt_dr_sh = {view[tpm_pkg::LINE_TDI], dr_sh_ff[7:1]};
        // the probe cannot be stalled, so a full fifo drops and flags
        tpm_pkg::TPM_UPD_DR: nxt_ovf = ovf_ff || !fifo_ready;
        default: nxt_ir = ir_ff;
      endcase
    end
    if (tck_fall) begin
      nxt_tdo = (tap_ff == tpm_pkg::TPM_SHIFT_IR) ? ir_sh_ff[0]
                                                 : dr_sh_ff[0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel_ff <= tpm_pkg::SEL_RESET_VAL;
      tck_prev_ff <= 1'b1;
      tap_ff <= tpm_pkg::TPM_TLR;
      ir_sh_ff <= tpm_pkg::IR_RESET_VAL;
      ir_ff <= tpm_pkg::IR_RESET_VAL;
      dr_sh_ff <= 8'h00;
      tdo_ff <= 1'b1;
      ovf_ff <= 1'b0;
      pad_ff <= '0;
    end else begin
      sel_ff <= nxt_sel;
      tck_prev_ff <= view[tpm_pkg::LINE_TCK];
      tap_ff <= nxt_tap;
      ir_sh_ff <= nxt_ir_sh;
      ir_ff <= nxt_ir;
      dr_sh_ff <= nxt_dr_sh;
      tdo_ff <= nxt_tdo;
      ovf_ff <= nxt_ovf;
      pad_ff <= nxt_pad;
    end
  end

  tpm_fifo #(
    .WIDTH(tpm_pkg::DR_W),
    .DEPTH(tpm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(dr_sh_ff),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign pad_drive = pad_ff;
  assign gpio_in = sync2_ff;
  assign instr = ir_ff;
  assign overflow = ovf_ff;
  assign tap_state = tap_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_tck_fall;
    tck_fall;
  endsequence
  sequence s_shift_rise;
    tck_rise && (tap_ff == tpm_pkg::TPM_SHIFT_DR);
  endsequence

  chk_reset_primary: assert property (
    @(posedge core_clk) disable iff (1'b0)
    $fell(reset) |-> (sel_ff == 4'h0 && pad_drive.oe == 4'h0))
    else $error("pads not in test role after reset");
  chk_alt_needs_both: assert property (
    pad_drive.oe[tpm_pkg::LINE_TDI] |->
    $past(periph_enable[0] && periph_select[0], 2))
    else $error("pad lent out without enable and select");
  chk_tdi_sampled: assert property (
    s_shift_rise |=> dr_sh_ff[7] == $past(view[tpm_pkg::LINE_TDI]))
    else $error("data input not sampled on rising edge");
  chk_tdo_enable: assert property (
    (pad_drive.oe[tpm_pkg::LINE_TDO] && !$past(sel_ff[1]))
    |-> $past(is_shift(tap_ff)))
    else $error("data output driven outside shift states");
  chk_tdo_falling: assert property (
    $changed(tdo_ff) |-> $past(tck_fall))
    else $error("data output changed off a falling edge");
  chk_gpio_dir: assert property (
    $past(sel_ff[0]) |->
    pad_drive.oe[tpm_pkg::LINE_TDI] == $past(gpio_ctl.dir[0]))
    else $error("port direction not honoured");
  chk_tap_steps: assert property (
    $changed(tap_ff) |-> $past(tck_rise))
    else $error("controller moved without a rising edge");
  chk_gpio_quiet: assert property (
    sel_ff[tpm_pkg::LINE_TCK] |=> $stable(tap_ff))
    else $error("lent clock pad disturbed the controller");
  chk_tdo_follows: assert property (
    s_tck_fall ##1 !tck_rise |-> ##1 $stable(tdo_ff))
    else $error("data output moved between edges");
endmodule

// [shared/tpm_pkg.sv]
// constants, types and carriers shared by the test-port pin mux
package tpm_pkg;
  localparam int PIN_COUNT = 4;
  // pin index of each shared line
  localparam int LINE_TDI = 0;
  localparam int LINE_TDO = 1;
  localparam int LINE_TCK = 2;
  localparam int LINE_TMS = 3;
  localparam int IR_W = 4;
  localparam int DR_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET_VAL = 4'hF;
  localparam logic [IR_W-1:0] IR_DATA_SEL = 4'h2;
  localparam logic [PIN_COUNT-1:0] SEL_RESET_VAL = 4'h0;
  localparam logic [PIN_COUNT-1:0] PULLUP_LEVEL = 4'hF;

  typedef enum logic [3:0] {
    TPM_TLR = 4'h0,
    TPM_IDLE = 4'h1,
    TPM_SEL_DR = 4'h3,
    TPM_CAP_DR = 4'h2,
    TPM_SHIFT_DR = 4'h6,
    TPM_EXIT1_DR = 4'h7,
    TPM_PAUSE_DR = 4'h5,
    TPM_EXIT2_DR = 4'h4,
    TPM_UPD_DR = 4'hC,
    TPM_SEL_IR = 4'hD,
    TPM_CAP_IR = 4'hF,
    TPM_SHIFT_IR = 4'hE,
    TPM_EXIT1_IR = 4'hA,
    TPM_PAUSE_IR = 4'hB,
    TPM_EXIT2_IR = 4'h9,
    TPM_UPD_IR = 4'h8
  } tpm_tap_e;

  // drive side of the four shared pads
  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe;
  } tpm_pad_s;

  // software view of the general-purpose role
  typedef struct packed {
    logic [PIN_COUNT-1:0] dir;
    logic [PIN_COUNT-1:0] out;
  } tpm_gpio_s;
endpackage

// [tb/tb.sv]
// self-checking bench for the test-port pin mux
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] pad_in, periph_enable, periph_select, gpio_in, instr;
  logic [3:0] p_drv, p_en;
  logic [7:0] capture_word, rx_data, d;
  logic rx_ready, rx_valid, overflow;
  tpm_pkg::tpm_pad_s pad_drive;
  tpm_pkg::tpm_gpio_s gpio_ctl;
  tpm_pkg::tpm_tap_e tap_state;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  always #50 core_clk = ~core_clk;
  // every pad pulled up; device drive wins, then the probe
  assign pad_in = (pad_drive.oe & pad_drive.out)
                | (~pad_drive.oe & ((p_en & p_drv) | ~p_en));
  tpm_pin_mux uut (.core_clk(core_clk), .reset(reset), .pad_in(pad_in),
    .pad_drive(pad_drive), .periph_enable(periph_enable),
    .periph_select(periph_select), .gpio_ctl(gpio_ctl),
    .gpio_in(gpio_in), .capture_word(capture_word), .instr(instr),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .overflow(overflow), .tap_state(tap_state));
  tpm_probe probe (.core_clk(core_clk), .tdo_pad(pad_in[1]), .drv(p_drv),
    .drv_en(p_en));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic dr(input logic [7:0] din);
    probe.moves(3, 8'h01);
    repeat (2) @(negedge core_clk);
    chk("tdo enable", 8'h01, {7'h0, pad_drive.oe[1]});
    probe.shift(8, din, d);
    chk("dr out", 8'hA5, d);
    probe.moves(2, 8'h01);
  endtask
  task automatic pop(input logic [7:0] exp);
    chk("rx valid", 8'h01, {7'h0, rx_valid});
    chk("rx data", exp, rx_data);
    rx_ready = 1'b1;
    @(negedge core_clk);
    rx_ready = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic t_reset();
    chk("tap", {4'h0, tpm_pkg::TPM_TLR}, {4'h0, tap_state});
    chk("instr", 8'h0F, {4'h0, instr});
    chk("pad oe", 8'h00, {4'h0, pad_drive.oe});
    chk("overflow", 8'h00, {7'h0, overflow});
    $display("test reset done");
  endtask
  task automatic t_ir();
    probe.moves(5, 8'h06);
    repeat (2) @(negedge core_clk);
    chk("tdo enable", 8'h01, {7'h0, pad_drive.oe[1]});
    probe.shift(4, 8'h02, d);
    chk("ir out", 8'h01, d & 8'h0F);
    probe.moves(2, 8'h01);
    chk("instr", 8'h02, {4'h0, instr});
    chk("tdo idle", 8'h00, {7'h0, pad_drive.oe[1]});
    $display("test instruction done");
  endtask
  task automatic t_dr();
    dr(8'h3C);
    // undriven data input must shift in ones
    probe.tdi_drive(1'b0);
    dr(8'h00);
    probe.tdi_drive(1'b1);
    pop(8'h3C);
    pop(8'hFF);
    chk("rx empty", 8'h00, {7'h0, rx_valid});
    $display("test data done");
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 32; i++) dr(8'(i));
    chk("overflow", 8'h00, {7'h0, overflow});
    dr(8'hEE);
    chk("overflow", 8'h01, {7'h0, overflow});
    for (int i = 0; i < 32; i++) pop(8'(i));
    chk("rx empty", 8'h00, {7'h0, rx_valid});
    $display("test fifo done");
  endtask
  task automatic t_gpio();
    probe.tdi_drive(1'b0);
    gpio_ctl.dir = 4'h3;
    gpio_ctl.out = 4'h2;
    periph_select = 4'hF;
    repeat (4) @(negedge core_clk);
    chk("oe select only", 8'h00, {4'h0, pad_drive.oe});
    periph_select = 4'h0;
    periph_enable = 4'hF;
    repeat (4) @(negedge core_clk);
    chk("oe enable only", 8'h00, {4'h0, pad_drive.oe});
    periph_select = 4'hF;
    repeat (4) @(negedge core_clk);
    chk("gpio oe", 8'h03, {4'h0, pad_drive.oe});
    chk("gpio out", 8'h02, {6'h0, pad_drive.out[1:0]});
    chk("gpio in", 8'h02, {6'h0, gpio_in[1:0]});
    probe.moves(5, 8'h1F);
    chk("tap held", {4'h0, tpm_pkg::TPM_IDLE}, {4'h0, tap_state});
    periph_select = 4'h0;
    periph_enable = 4'h0;
    probe.tdi_drive(1'b1);
    repeat (4) @(negedge core_clk);
    $display("test gpio done");
  endtask
  task automatic t_tlr();
    probe.moves(5, 8'h1F);
    chk("tap", {4'h0, tpm_pkg::TPM_TLR}, {4'h0, tap_state});
    $display("test tlr done");
  endtask
  initial begin
    periph_enable = 4'h0;
    periph_select = 4'h0;
    gpio_ctl = '0;
    capture_word = 8'hA5;
    rx_ready = 1'b0;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_ir();
    t_dr();
    t_fifo();
    t_gpio();
    t_tlr();
    end_of_test();
  end
endmodule

// [tb/tpm_probe.sv]
// debug probe model driving the shared test pads
module tpm_probe (
  input wire logic core_clk,
  input wire logic tdo_pad,
  output logic [3:0] drv,
  output logic [3:0] drv_en
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    drv = 4'h0;
    drv_en = 4'hD;
  end
  // tck stands still low between operations; half period is 4 clocks
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge core_clk);
    drv[3] = tms;
    drv[0] = tdi;
    repeat (3) @(negedge core_clk);
    drv[2] = 1'b1;
    // tdo stands until the next fall, so sampling late is safe
    repeat (2) @(negedge core_clk);
    tdo = tdo_pad;
    repeat (2) @(negedge core_clk);
    drv[2] = 1'b0;
  endtask
  // releasing the data input lets the pull-up show through
  task automatic tdi_drive(input logic en);
    drv_en[0] = en;
  endtask
  task automatic moves(input int n, input logic [7:0] tms);
    logic b;
    for (int i = 0; i < n; i++) step(tms[i], 1'b1, b);
  endtask
  task automatic shift(input int n, input logic [7:0] din,
                       output logic [7:0] dout);
    logic b;
    dout = 8'h00;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
endmodule
